// ==== shared/hia_pkg.sv ====
package hia_pkg;

    // Bus geometry.
    localparam int APB_AW = 12;
    localparam int APB_DW = 32;

    // Per-function latched status and enable registers.
    localparam logic [APB_AW-1:0] OFS_TXQ_STAT = 12'h000;
    localparam logic [APB_AW-1:0] OFS_TXQ_EN = 12'h004;
    localparam logic [APB_AW-1:0] OFS_TXP_STAT = 12'h008;
    localparam logic [APB_AW-1:0] OFS_TXP_EN = 12'h00c;
    localparam logic [APB_AW-1:0] OFS_RXP_STAT = 12'h010;
    localparam logic [APB_AW-1:0] OFS_RXP_EN = 12'h014;
    localparam logic [APB_AW-1:0] OFS_X86_STAT = 12'h018;
    localparam logic [APB_AW-1:0] OFS_X86_EN = 12'h01c;
    localparam logic [APB_AW-1:0] OFS_RXQ_STAT = 12'h020;
    localparam logic [APB_AW-1:0] OFS_RXQ_EN = 12'h024;
    localparam logic [APB_AW-1:0] OFS_BERT_STAT = 12'h028;
    localparam logic [APB_AW-1:0] OFS_BERT_EN = 12'h02c;

    // Global registers.
    localparam logic [APB_AW-1:0] OFS_CTRL = 12'h0f0;
    localparam logic [APB_AW-1:0] OFS_GRP_STAT = 12'h0f4;
    localparam logic [APB_AW-1:0] OFS_GRP_EN = 12'h0f8;
    localparam logic [APB_AW-1:0] OFS_IDENT = 12'h0fc;

    // Field widths.
    localparam int TXQ_W = 4;
    localparam int TXP_W = 1;
    localparam int RXP_W = 8;
    localparam int X86_W = 4;
    localparam int RXQ_W = 4;
    localparam int BERT_W = 4;
    localparam int GRP_W = 4;
    localparam int IDENT_W = 16;

    // Global control bits.
    localparam int CTRL_SRST = 0;
    localparam int CTRL_DRIVE = 1;
    localparam int CTRL_CONN = 2;
    localparam int CTRL_QPR = 3;
    localparam int CTRL_W = 4;

    // Global group bits.
    localparam int GRP_LINE = 0;
    localparam int GRP_SYS = 1;
    localparam int GRP_BERT = 2;
    localparam int GRP_CONN = 3;

    // Transmit queue status bits.
    localparam int TXQ_HIGH = 0;
    localparam int TXQ_LOW = 1;
    localparam int TXQ_QOVF = 2;
    localparam int TXQ_FOVF = 3;

    // Identification values are arbitrary.
    localparam logic [IDENT_W-1:0] IDENT_LOW_DEF = 16'h1234;
    localparam logic [IDENT_W-1:0] IDENT_HIGH_DEF = 16'h00c5;

    localparam logic [APB_DW-1:0] WORD_ZERO = 32'h0000_0000;

endpackage : hia_pkg

// ==== verilog/hia_latch_bank.sv ====
module hia_latch_bank
    import hia_pkg::*;
#(
    parameter int W = 4,
    parameter bit REVERSE_EN = 1'b0
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    input wire logic srst,
    // Events and host writes.
    input wire logic [W-1:0] set_evt,
    input wire logic wr_stat,
    input wire logic wr_en,
    input wire logic [W-1:0] wdata,
    // State.
    output logic [W-1:0] status,
    output logic [W-1:0] enable,
    output logic pending
);

    logic [W-1:0] status_reg;
    logic [W-1:0] status_next;
    logic [W-1:0] enable_reg;
    logic [W-1:0] enable_next;
    logic [W-1:0] enable_view;

    // Maps the enable register onto the status bit order.
    function automatic logic [W-1:0] reorder(input logic [W-1:0] v);
        logic [W-1:0] r;
        r = v;
        for (int i = 0; i < W; i++) begin
            r[i] = v[W-1-i];
        end
        return r;
    endfunction : reorder

    // An event in the clearing cycle survives because the set is or-ed last.
    assign status_next = srst ? '0 :
        ((status_reg & ~(wr_stat ? wdata : '0)) | set_evt);
    assign enable_next = srst ? '0 : (wr_en ? wdata : enable_reg);
    assign enable_view = REVERSE_EN ? reorder(enable_reg) : enable_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            status_reg <= '0;
            enable_reg <= '0;
        end else begin
            status_reg <= status_next;
            enable_reg <= enable_next;
        end
    end

    assign status = status_reg;
    assign enable = enable_reg;
    assign pending = |(status_reg & enable_view);

endmodule : hia_latch_bank

// ==== verilog/hia_top.sv ====
// Local design decisions: the address map and register access over APB.
module hia_top
    import hia_pkg::*;
#(
    parameter logic [IDENT_W-1:0] IDENT_LOW = IDENT_LOW_DEF,
    parameter logic [IDENT_W-1:0] IDENT_HIGH = IDENT_HIGH_DEF
) (
    // Clock and reset.
    input wire logic clk,
    input wire logic nrst,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [APB_AW-1:0] paddr,
    input wire logic [APB_DW-1:0] pwdata,
    output logic pready,
    output logic [APB_DW-1:0] prdata,
    output logic pslverr,
    // Function events, high for each cycle the condition is seen.
    input wire logic [TXQ_W-1:0] txq_evt,
    input wire logic [TXP_W-1:0] txp_evt,
    input wire logic [RXP_W-1:0] rxp_evt,
    input wire logic [X86_W-1:0] x86_evt,
    input wire logic [RXQ_W-1:0] rxq_evt,
    input wire logic [BERT_W-1:0] bert_evt,
    // Interrupt pin.
    output logic irq_n_out,
    output logic irq_oe,
    // Global controls to the rest of the device.
    output logic soft_reset_active,
    output logic connection_enable,
    output logic qptr_reset_pulse
);

    // Bus phases, address decode, latched banks and global registers.
    logic setup_ph, wr_acc;
    logic hit_txq_stat, hit_txq_en, hit_txp_stat, hit_txp_en;
    logic hit_rxp_stat, hit_rxp_en, hit_x86_stat, hit_x86_en;
    logic hit_rxq_stat, hit_rxq_en, hit_bert_stat, hit_bert_en;
    logic hit_ctrl, hit_grp_stat, hit_grp_en, hit_ident, addr_ok;
    logic [APB_DW-1:0] rd_word;
    logic [TXQ_W-1:0] txq_stat, txq_en;
    logic [TXP_W-1:0] txp_stat, txp_en;
    logic [RXP_W-1:0] rxp_stat, rxp_en;
    logic [X86_W-1:0] x86_stat, x86_en;
    logic [RXQ_W-1:0] rxq_stat, rxq_en;
    logic [BERT_W-1:0] bert_stat, bert_en;
    logic pend_txq, pend_txp, pend_rxp, pend_x86, pend_rxq, pend_bert;
    logic srst_reg, srst_next, drive_sel_reg, drive_sel_next;
    logic conn_reg, conn_next, qpr_reg, qpr_next;
    logic [GRP_W-1:0] grp_en_reg, grp_en_next, grp_status;
    logic irq_req, irq_active_reg, pslverr_reg;
    logic [APB_DW-1:0] prdata_reg;

    assign setup_ph = psel && !penable;
    assign wr_acc = psel && penable && pwrite;

    assign hit_txq_stat = (paddr == OFS_TXQ_STAT);
    assign hit_txq_en = (paddr == OFS_TXQ_EN);
    assign hit_txp_stat = (paddr == OFS_TXP_STAT);
    assign hit_txp_en = (paddr == OFS_TXP_EN);
    assign hit_rxp_stat = (paddr == OFS_RXP_STAT);
    assign hit_rxp_en = (paddr == OFS_RXP_EN);
    assign hit_x86_stat = (paddr == OFS_X86_STAT);
    assign hit_x86_en = (paddr == OFS_X86_EN);
    assign hit_rxq_stat = (paddr == OFS_RXQ_STAT);
    assign hit_rxq_en = (paddr == OFS_RXQ_EN);
    assign hit_bert_stat = (paddr == OFS_BERT_STAT);
    assign hit_bert_en = (paddr == OFS_BERT_EN);
    assign hit_ctrl = (paddr == OFS_CTRL);
    assign hit_grp_stat = (paddr == OFS_GRP_STAT);
    assign hit_grp_en = (paddr == OFS_GRP_EN);
    assign hit_ident = (paddr == OFS_IDENT);
    assign addr_ok = hit_txq_stat || hit_txq_en || hit_txp_stat ||
        hit_txp_en || hit_rxp_stat || hit_rxp_en || hit_x86_stat ||
        hit_x86_en || hit_rxq_stat || hit_rxq_en || hit_bert_stat ||
        hit_bert_en || hit_ctrl || hit_grp_stat || hit_grp_en || hit_ident;

    // Reads have no side effect; clearing is only by writing ones, by soft reset or by the reset pin.
    assign rd_word =
        hit_txq_stat ? {{(APB_DW-TXQ_W){1'b0}}, txq_stat} :
        hit_txq_en ? {{(APB_DW-TXQ_W){1'b0}}, txq_en} :
        hit_txp_stat ? {{(APB_DW-TXP_W){1'b0}}, txp_stat} :
        hit_txp_en ? {{(APB_DW-TXP_W){1'b0}}, txp_en} :
        hit_rxp_stat ? {{(APB_DW-RXP_W){1'b0}}, rxp_stat} :
        hit_rxp_en ? {{(APB_DW-RXP_W){1'b0}}, rxp_en} :
        hit_x86_stat ? {{(APB_DW-X86_W){1'b0}}, x86_stat} :
        hit_x86_en ? {{(APB_DW-X86_W){1'b0}}, x86_en} :
        hit_rxq_stat ? {{(APB_DW-RXQ_W){1'b0}}, rxq_stat} :
        hit_rxq_en ? {{(APB_DW-RXQ_W){1'b0}}, rxq_en} :
        hit_bert_stat ? {{(APB_DW-BERT_W){1'b0}}, bert_stat} :
        hit_bert_en ? {{(APB_DW-BERT_W){1'b0}}, bert_en} :
        hit_ctrl ? {{(APB_DW-CTRL_W){1'b0}}, qpr_reg, conn_reg,
            drive_sel_reg, srst_reg} :
        hit_grp_stat ? {{(APB_DW-GRP_W){1'b0}}, grp_status} :
        hit_grp_en ? {{(APB_DW-GRP_W){1'b0}}, grp_en_reg} :
        hit_ident ? {IDENT_HIGH, IDENT_LOW} :
        WORD_ZERO;

    // Transmit queue: high, low, queue overflow, FIFO overflow.
    hia_latch_bank #(.W(TXQ_W), .REVERSE_EN(1'b0)) u_txq (
        .clk(clk),
        .nrst(nrst),
        .srst(srst_reg),
        .set_evt(txq_evt),
        .wr_stat(wr_acc && hit_txq_stat),
        .wr_en(wr_acc && hit_txq_en),
        .wdata(pwdata[TXQ_W-1:0]),
        .status(txq_stat),
        .enable(txq_en),
        .pending(pend_txq)
    );

    // Transmit packet insertion finished.
    hia_latch_bank #(.W(TXP_W), .REVERSE_EN(1'b0)) u_txp (
        .clk(clk),
        .nrst(nrst),
        .srst(srst_reg),
        .set_evt(txp_evt),
        .wr_stat(wr_acc && hit_txp_stat),
        .wr_en(wr_acc && hit_txp_en),
        .wdata(pwdata[TXP_W-1:0]),
        .status(txp_stat),
        .enable(txp_en),
        .pending(pend_txp)
    );

    // Receive packet errors and error counter events.
    hia_latch_bank #(.W(RXP_W), .REVERSE_EN(1'b0)) u_rxp (
        .clk(clk),
        .nrst(nrst),
        .srst(srst_reg),
        .set_evt(rxp_evt),
        .wr_stat(wr_acc && hit_rxp_stat),
        .wr_en(wr_acc && hit_rxp_en),
        .wdata(pwdata[RXP_W-1:0]),
        .status(rxp_stat),
        .enable(rxp_en),
        .pending(pend_rxp)
    );

    // Header mismatches: address, control, SAPI low, SAPI high.
    hia_latch_bank #(.W(X86_W), .REVERSE_EN(1'b0)) u_x86 (
        .clk(clk),
        .nrst(nrst),
        .srst(srst_reg),
        .set_evt(x86_evt),
        .wr_stat(wr_acc && hit_x86_stat),
        .wr_en(wr_acc && hit_x86_en),
        .wdata(pwdata[X86_W-1:0]),
        .status(x86_stat),
        .enable(x86_en),
        .pending(pend_x86)
    );

    // Receive queue; its enable register holds the bits in reverse order.
    hia_latch_bank #(.W(RXQ_W), .REVERSE_EN(1'b1)) u_rxq (
        .clk(clk),
        .nrst(nrst),
        .srst(srst_reg),
        .set_evt(rxq_evt),
        .wr_stat(wr_acc && hit_rxq_stat),
        .wr_en(wr_acc && hit_rxq_en),
        .wdata(pwdata[RXQ_W-1:0]),
        .status(rxq_stat),
        .enable(rxq_en),
        .pending(pend_rxq)
    );

    // BERT: detected, monitor update, out of sync, error count.
    hia_latch_bank #(.W(BERT_W), .REVERSE_EN(1'b0)) u_bert (
        .clk(clk),
        .nrst(nrst),
        .srst(srst_reg),
        .set_evt(bert_evt),
        .wr_stat(wr_acc && hit_bert_stat),
        .wr_en(wr_acc && hit_bert_en),
        .wdata(pwdata[BERT_W-1:0]),
        .status(bert_stat),
        .enable(bert_en),
        .pending(pend_bert)
    );

    // Live group status, no storage of its own.
    assign grp_status[GRP_LINE] = pend_txq || pend_txp || pend_rxp ||
        pend_x86;
    assign grp_status[GRP_SYS] = pend_rxq;
    assign grp_status[GRP_BERT] = pend_bert;
    assign grp_status[GRP_CONN] = pend_txp || pend_rxp;

    // The soft reset bit itself is cleared only by the pin or a zero write.
    assign srst_next = (wr_acc && hit_ctrl) ? pwdata[CTRL_SRST] :
        srst_reg;
    assign drive_sel_next = srst_reg ? 1'b0 :
        ((wr_acc && hit_ctrl) ? pwdata[CTRL_DRIVE] : drive_sel_reg);
    assign conn_next = srst_reg ? 1'b0 :
        ((wr_acc && hit_ctrl) ? pwdata[CTRL_CONN] : conn_reg);
    assign qpr_next = !srst_reg && wr_acc && hit_ctrl && pwdata[CTRL_QPR];
    assign grp_en_next = srst_reg ? '0 :
        ((wr_acc && hit_grp_en) ? pwdata[GRP_W-1:0] : grp_en_reg);
    assign irq_req = |(grp_status & grp_en_reg) && !srst_reg;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            srst_reg <= 1'b0;
            drive_sel_reg <= 1'b0;
            conn_reg <= 1'b0;
            qpr_reg <= 1'b0;
            grp_en_reg <= '0;
            irq_active_reg <= 1'b0;
        end else begin
            srst_reg <= srst_next;
            drive_sel_reg <= drive_sel_next;
            conn_reg <= conn_next;
            qpr_reg <= qpr_next;
            grp_en_reg <= grp_en_next;
            irq_active_reg <= irq_req;
        end
    end

    // Read data and error are captured in the setup cycle.
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            prdata_reg <= WORD_ZERO;
            pslverr_reg <= 1'b0;
        end else if (setup_ph) begin
            prdata_reg <= rd_word;
            pslverr_reg <= !addr_ok;
        end
    end

    assign pready = 1'b1;
    assign prdata = prdata_reg;
    assign pslverr = pslverr_reg && psel && penable;

    // Low when active; idle is driven high or released for a pull-up.
    assign irq_n_out = !irq_active_reg;
    assign irq_oe = irq_active_reg || drive_sel_reg;
    assign soft_reset_active = srst_reg;
    assign connection_enable = conn_reg;
    assign qptr_reset_pulse = qpr_reg;

    property p_w1c_clear;
        @(posedge clk) disable iff (!nrst)
        (wr_acc && hit_txq_stat && pwdata[TXQ_HIGH] && !txq_evt[TXQ_HIGH])
        |=> !txq_stat[TXQ_HIGH];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear)
        else $error("latched bit not cleared by one");

    property p_w0_keep;
        @(posedge clk) disable iff (!nrst)
        (wr_acc && hit_txq_stat && !pwdata[TXQ_LOW] && txq_stat[TXQ_LOW] &&
            !srst_reg) |=> txq_stat[TXQ_LOW];
    endproperty
    a_w0_keep: assert property (p_w0_keep)
        else $error("latched bit lost on zero write");

    property p_set_wins;
        @(posedge clk) disable iff (!nrst)
        (wr_acc && hit_txq_stat && pwdata[TXQ_FOVF] && txq_evt[TXQ_FOVF] &&
            !srst_reg) |=> txq_stat[TXQ_FOVF];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event lost during clear");

    property p_disabled_sets;
        @(posedge clk) disable iff (!nrst)
        (bert_evt[0] && !bert_en[0] && !srst_reg) |=> bert_stat[0];
    endproperty
    a_disabled_sets: assert property (p_disabled_sets)
        else $error("disabled latched bit did not set");

    property p_rxq_masked;
        @(posedge clk) disable iff (!nrst)
        (rxq_stat != '0 && rxq_en == '0) |-> !grp_status[GRP_SYS];
    endproperty
    a_rxq_masked: assert property (p_rxq_masked)
        else $error("disabled condition reached group");

    property p_bert_group;
        @(posedge clk) disable iff (!nrst)
        (bert_evt[0] && bert_en[0] && !srst_reg && !(wr_acc && hit_bert_en))
        |=> grp_status[GRP_BERT];
    endproperty
    a_bert_group: assert property (p_bert_group)
        else $error("bert group not set");

    property p_group_block;
        @(posedge clk) disable iff (!nrst)
        (grp_en_reg == '0) |=> irq_n_out;
    endproperty
    a_group_block: assert property (p_group_block)
        else $error("interrupt with groups disabled");

    property p_no_irq_in_reset;
        @(posedge clk) disable iff (!nrst)
        srst_reg |=> (irq_n_out && !irq_oe);
    endproperty
    a_no_irq_in_reset: assert property (p_no_irq_in_reset)
        else $error("interrupt during soft reset");

    property p_irq_assert;
        @(posedge clk) disable iff (!nrst)
        (|(grp_status & grp_en_reg) && !srst_reg) |=> (!irq_n_out && irq_oe);
    endproperty
    a_irq_assert: assert property (p_irq_assert)
        else $error("interrupt not asserted");

    property p_release_idle;
        @(posedge clk) disable iff (!nrst)
        (wr_acc && hit_ctrl && !pwdata[CTRL_DRIVE] && !irq_req) |=> !irq_oe;
    endproperty
    a_release_idle: assert property (p_release_idle)
        else $error("idle pin driven in release mode");

    property p_srst_sticky;
        @(posedge clk) disable iff (!nrst)
        (srst_reg && !(wr_acc && hit_ctrl && !pwdata[CTRL_SRST]))
        |=> srst_reg;
    endproperty
    a_srst_sticky: assert property (p_srst_sticky)
        else $error("soft reset bit dropped");

    property p_ident_read;
        @(posedge clk) disable iff (!nrst)
        (setup_ph && hit_ident) |=> (prdata == {IDENT_HIGH, IDENT_LOW});
    endproperty
    a_ident_read: assert property (p_ident_read)
        else $error("wrong identification word");

    c_irq: cover property (@(posedge clk) disable iff (!nrst)
        $fell(irq_n_out));
    c_clear: cover property (@(posedge clk) disable iff (!nrst)
        txq_stat[TXQ_HIGH] ##1 !txq_stat[TXQ_HIGH]);
    c_srst: cover property (@(posedge clk) disable iff (!nrst)
        $rose(srst_reg));
    c_err: cover property (@(posedge clk) disable iff (!nrst)
        pslverr);

endmodule : hia_top

// ==== dv/hia_host.sv ====
module hia_host
    import hia_pkg::*;
(
    // Clock.
    input wire logic clk,
    // APB master side.
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [APB_AW-1:0] paddr,
    output logic [APB_DW-1:0] pwdata,
    input wire logic pready,
    input wire logic [APB_DW-1:0] prdata,
    input wire logic pslverr
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
    end

    // The request stands unchanged until pready is seen high at an edge or 64 edges pass.
    task automatic xfer(input logic wr, input logic [APB_AW-1:0] a,
                        input logic [APB_DW-1:0] d,
                        output logic [APB_DW-1:0] q, output logic e,
                        output logic to);
        int n;
        n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 64);
        q = prdata;
        e = pslverr;
        to = (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : xfer
endmodule : hia_host

// ==== dv/tb_top.sv ====
module tb_top
    import hia_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int RST_WAIT_CYC = 10;

    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic psel, penable, pwrite, pready, pslverr;
    logic [APB_AW-1:0] paddr;
    logic [APB_DW-1:0] pwdata, prdata;
    logic [3:0] txq_evt = '0, x86_evt = '0, rxq_evt = '0, bert_evt = '0;
    logic [0:0] txp_evt = '0;
    logic [7:0] rxp_evt = '0;
    logic irq_n_out, irq_oe, soft_reset_active, connection_enable;
    logic qptr_reset_pulse;
    int err_count = 0;
    int checked = 0;
    integer seed;

    always #10 clk = ~clk;

    hia_top hia_top_i (.clk(clk), .nrst(nrst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .txq_evt(txq_evt), .txp_evt(txp_evt), .rxp_evt(rxp_evt),
        .x86_evt(x86_evt), .rxq_evt(rxq_evt), .bert_evt(bert_evt),
        .irq_n_out(irq_n_out), .irq_oe(irq_oe),
        .soft_reset_active(soft_reset_active),
        .connection_enable(connection_enable),
        .qptr_reset_pulse(qptr_reset_pulse));

    hia_host hia_host_i (.clk(clk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr));

    task automatic complete_run();
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : complete_run

    task automatic chk(input string n, input logic [31:0] x,
                       input logic [31:0] g);
        checked++;
        if (g !== x) begin
            $display("MISMATCH %s expected %h seen %h", n, x, g);
            err_count++;
        end
    endtask : chk

    task automatic acc(input logic w, input logic [APB_AW-1:0] a,
                       input logic [APB_DW-1:0] d,
                       output logic [APB_DW-1:0] q, output logic e);
        logic to;
        hia_host_i.xfer(w, a, d, q, e, to);
        if (to) begin
            err_count++;
            complete_run();
        end
    endtask : acc

    task automatic wr(input logic [APB_AW-1:0] a, input logic [31:0] d);
        logic [APB_DW-1:0] q;
        logic e;
        acc(1'b1, a, d, q, e);
        chk("pslverr", 32'h0, {31'h0, e});
    endtask : wr

    task automatic rdchk(input string n, input logic [APB_AW-1:0] a,
                         input logic [31:0] x);
        logic [APB_DW-1:0] q;
        logic e;
        acc(1'b0, a, '0, q, e);
        chk(n, x, q);
    endtask : rdchk

    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : settle

    task automatic pins(input logic xn, input logic xoe);
        chk("irq_n_out", {31'h0, xn}, {31'h0, irq_n_out});
        chk("irq_oe", {31'h0, xoe}, {31'h0, irq_oe});
    endtask : pins

    // One-cycle event pulse on the chosen function's input.
    task automatic pulse(input int s, input logic [7:0] b);
        @(posedge clk);
        case (s)
            0: txq_evt <= b[3:0];
            1: txp_evt <= b[0:0];
            2: rxp_evt <= b;
            3: x86_evt <= b[3:0];
            4: rxq_evt <= b[3:0];
            default: bert_evt <= b[3:0];
        endcase
        @(posedge clk);
        {txq_evt, txp_evt, rxp_evt, x86_evt, rxq_evt, bert_evt} <= '0;
    endtask : pulse

    function automatic int src_w(input int s);
        return (s == 1) ? 1 : (s == 2) ? 8 : 4;
    endfunction : src_w

    // Receive queue enable bits run in reverse order to its status bits.
    function automatic logic [31:0] en_bit(input int s, input int b);
        return (s == 4) ? 32'h1 << (3 - b) : 32'h1 << b;
    endfunction : en_bit

    function automatic logic [31:0] grp_of(input int s);
        case (s)
            1, 2: return 32'h9;
            4: return 32'h2;
            5: return 32'h4;
            default: return 32'h1;
        endcase
    endfunction : grp_of

    initial begin
        logic [APB_DW-1:0] q;
        logic e;
        logic [APB_AW-1:0] st;
        logic [31:0] bm;
        int b;
        seed = 32'h483b;
        repeat (3) @(posedge clk);
        nrst <= 1'b1;
        repeat (RST_WAIT_CYC) @(posedge clk);
        pins(1'b1, 1'b0);
        rdchk("ident", OFS_IDENT, {IDENT_HIGH_DEF, IDENT_LOW_DEF});
        for (int i = 0; i < 12; i++) wr(12'(i * 4), 32'h0);
        wr(OFS_CTRL, 32'h0);
        acc(1'b1, 12'h10c, 32'hffff_ffff, q, e);
        chk("pslverr", 32'h1, {31'h0, e});
        wr(OFS_GRP_EN, 32'hf);
        for (int s = 0; s < 6; s++) begin
            b = $unsigned($random(seed)) % src_w(s);
            bm = 32'h1 << b;
            st = 12'(s * 8);
            pulse(s, bm[7:0]);
            settle(2);
            rdchk("latched", st, bm);
            rdchk("group", OFS_GRP_STAT, 32'h0);
            pins(1'b1, 1'b0);
            wr(st + 12'h4, en_bit(s, b));
            rdchk("enable", st + 12'h4, en_bit(s, b));
            rdchk("group", OFS_GRP_STAT, grp_of(s));
            settle(2);
            pins(1'b0, 1'b1);
            rdchk("latched", st, bm);
            wr(st, ~bm);
            rdchk("latched", st, bm);
            wr(OFS_GRP_EN, 32'h0);
            settle(2);
            pins(1'b1, 1'b0);
            wr(OFS_GRP_EN, 32'hf);
            wr(st, bm);
            rdchk("latched", st, 32'h0);
            rdchk("group", OFS_GRP_STAT, 32'h0);
            settle(2);
            pins(1'b1, 1'b0);
            wr(st + 12'h4, 32'h0);
        end
        // An event landing on the clearing edge must survive the clear.
        pulse(0, 8'ha);
        fork
            wr(OFS_TXQ_STAT, 32'h8);
            begin
                repeat (2) @(posedge clk);
                txq_evt <= 4'h8;
                @(posedge clk);
                txq_evt <= '0;
            end
        join
        rdchk("latched", OFS_TXQ_STAT, 32'ha);
        wr(OFS_TXQ_STAT, 32'ha);
        rdchk("latched", OFS_TXQ_STAT, 32'h0);
        pulse(5, 8'h1);
        wr(OFS_BERT_EN, 32'h1);
        rdchk("group", OFS_GRP_STAT, 32'h4);
        wr(OFS_BERT_STAT, 32'h1);
        pulse(5, 8'h1);
        rdchk("group", OFS_GRP_STAT, 32'h4);
        wr(OFS_BERT_STAT, 32'h1);
        wr(OFS_BERT_EN, 32'h0);
        rdchk("group", OFS_GRP_STAT, 32'h0);
        wr(OFS_TXQ_EN, 32'h1);
        pulse(0, 8'h1);
        settle(2);
        pins(1'b0, 1'b1);
        wr(OFS_CTRL, 32'h1);
        settle(1);
        chk("soft_reset", 32'h1, {31'h0, soft_reset_active});
        pins(1'b1, 1'b0);
        pulse(0, 8'h2);
        wr(OFS_CTRL, 32'h0);
        rdchk("latched", OFS_TXQ_STAT, 32'h0);
        rdchk("enable", OFS_TXQ_EN, 32'h0);
        wr(OFS_CTRL, 32'h6);
        rdchk("control", OFS_CTRL, 32'h6);
        settle(1);
        pins(1'b1, 1'b1);
        chk("connection", 32'h1, {31'h0, connection_enable});
        wr(OFS_CTRL, 32'h0);
        settle(1);
        pins(1'b1, 1'b0);
        wr(OFS_CTRL, 32'h8);
        settle(0);
        chk("qptr_reset", 32'h1, {31'h0, qptr_reset_pulse});
        settle(0);
        chk("qptr_reset", 32'h0, {31'h0, qptr_reset_pulse});
        rdchk("control", OFS_CTRL, 32'h0);
        complete_run();
    end
endmodule : tb_top
